// ---- common/mbs_pkg.sv ----
// Constants, types and decode helpers of the buck startup and fault sequencer
package mbs_pkg;

	localparam int unsigned CLK_HZ      = 32'h017D_7840;
	localparam int unsigned CLK_NS      = 32'h28;
	localparam int unsigned CYC_PER_US  = CLK_HZ / 32'h000F_4240;
	localparam int unsigned T_BOOT_NS   = 32'h12C;
	localparam int unsigned BOOT_CYC    = (T_BOOT_NS + CLK_NS - 32'h1) / CLK_NS;
	localparam int unsigned T_OVDLY_NS  = 32'h1388;
	localparam int unsigned OVDLY_CYC   = T_OVDLY_NS / CLK_NS;
	localparam int unsigned T_SETTLE_US = 32'h7D0;
	localparam int unsigned T_HICCUP_US = 32'h1770;
	localparam int unsigned T_OVWAIT_US = 32'h7D0;
	localparam int unsigned T_OKDLY_US  = 32'h7D0;
	localparam int unsigned T_TRANS_US  = 32'h7D0;

	// Switching period in clocks, fixed internal timebase of 500 kHz
	localparam logic [5:0]  PERIOD_CYC    = 6'h32;
	localparam logic [5:0]  HALF_CYC      = 6'h19;
	localparam logic [6:0]  LOCK_LOSS_CYC = 7'h64;
	localparam int unsigned RAMP_STEP_CYC = T_TRANS_US * CYC_PER_US / 32'h32;

	localparam logic [8:0]  OC_LIMIT = 9'h1BE;
	localparam logic [4:0]  OC_CLEAN = 5'h10;
	localparam logic [3:0]  OC_FAST  = 4'h7;
	localparam logic [2:0]  OV_MAX   = 3'h7;

	// Divider ratio scaled to 0..255, thresholds at midpoints between targets
	localparam logic [7:0]  TH_3  = 8'h1B;
	localparam logic [7:0]  TH_5  = 8'h49;
	localparam logic [7:0]  TH_6  = 8'h6D;
	localparam logic [7:0]  TH_8  = 8'h92;
	localparam logic [7:0]  TH_10 = 8'hB6;
	localparam logic [7:0]  TH_12 = 8'hE4;

	localparam logic [1:0]  REF_INTERNAL = 2'h0;
	localparam logic [1:0]  REF_FOLLOW   = 2'h1;
	localparam logic [1:0]  REF_SOFT     = 2'h2;

	typedef enum logic [3:0] {
		ST_OFF       = 4'h0,
		ST_CORE_UP   = 4'h1,
		ST_DRV_UP    = 4'h2,
		ST_SAMPLE    = 4'h3,
		ST_PLL       = 4'h4,
		ST_WAIT_BUS  = 4'h5,
		ST_PRECHARGE = 4'h6,
		ST_BOOT      = 4'h7,
		ST_RUN       = 4'h8,
		ST_HICCUP    = 4'h9,
		ST_OV_PULL   = 4'hA,
		ST_OV_WAIT   = 4'hB,
		ST_FAULT_WT  = 4'hC,
		ST_LATCHED   = 4'hD
	} mbs_state_t;

	// Comparator and pin inputs, all asynchronous to mclk
	typedef struct packed {
		logic       enable_above;
		logic       core_ok;
		logic       driver_ok;
		logic       trip_bus_in;
		logic       clock_lock_in;
		logic       is_master;
		logic       err_amp_high;
		logic [1:0] pwm_req;
		logic [1:0] oc_hit;
		logic       fb_above_uv;
		logic       fb_above_ov;
		logic       fb_below_half;
		logic       follow_above_ref;
		logic       ss_lowest;
		logic       ss_above_fb;
	} mbs_pins_t;

	typedef struct packed {
		logic [1:0] high_side_gate;
		logic [1:0] low_side_gate;
	} mbs_gates_t;

	function automatic logic [3:0] decode_phases(input logic [7:0] r);
		if (r < TH_3)
			return 4'h4;
		else if (r < TH_5)
			return 4'h3;
		else if (r < TH_6)
			return 4'h5;
		else if (r < TH_8)
			return 4'h6;
		else if (r < TH_10)
			return 4'h8;
		else if (r < TH_12)
			return 4'hA;
		else
			return 4'hC;
	endfunction

	// Chain delay is one phase step, period over phase count
	function automatic logic [5:0] chain_delay(input logic [3:0] n);
		return (n == 4'h0) ? 6'h0 : 6'(PERIOD_CYC / {2'h0, n});
	endfunction

endpackage

// ---- rtl/mbs_sync3.sv ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module mbs_sync3 #(
	parameter int unsigned W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] dout_d;

	// A bit moves only once stages two and three agree
	always_comb begin
		for (int i = 0; i < W; i++) begin
			dout_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : dout[i];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			dout <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			dout <= dout_d;
		end
	end
endmodule // mbs_sync3

// ---- rtl/mbs_sequencer.sv ----
// Startup, protection and output-good sequencer of one buck controller
// Behaviour
// [R1] Enable brings core, then driver supply, then ready
// [R2] Supply lockout stops switching, reruns full startup
// [R3] Sample phase select once, then start chain clock
// [R4] Decode divider ratio into phase count
// [R5] Hold trip bus low 2 ms, switch after rise
// [R6] Reference is lower of internal and follow
// [R7] Low gate on, then 300 ns boot, then switching
// [R8] Output-good after 2 ms if four conditions hold
// [R9] Fault pulls trip bus; low bus stops switching
// [R10] Both gates low until trip bus rises
// [R11] Over-current ends current cycle at once
// [R12] 446 summed over-currents fault; 16 clean cycles clear
// [R13] Master: 7 over-currents below half feedback fault
// [R14] Over-current: gates low, bus held 6 ms
// [R15] Restart with soft-start, gradual synchronous low gate
// [R16] Master over-voltage after 5 us: high off, low on
// [R17] Drop low gate below undervoltage, wait 2 ms
// [R18] Seventh over-voltage latches off until power cycled
// [R19] Output-good open drain, released inside window only on master, slave by chain lock
// [R20] 2 ms synchronous transition before output-good
// [R21] Trip bus wired-AND: drive low or release
`timescale 1ns/1ps
module mbs_sequencer #(
	parameter int unsigned SETTLE_CYC = mbs_pkg::T_SETTLE_US * mbs_pkg::CYC_PER_US,
	parameter int unsigned HICCUP_CYC = mbs_pkg::T_HICCUP_US * mbs_pkg::CYC_PER_US,
	parameter int unsigned OVWAIT_CYC = mbs_pkg::T_OVWAIT_US * mbs_pkg::CYC_PER_US,
	parameter int unsigned OKDLY_CYC  = mbs_pkg::T_OKDLY_US * mbs_pkg::CYC_PER_US
) (
	input  wire logic               mclk,
	input  wire logic               rst,
	input  wire mbs_pkg::mbs_pins_t pins,
	input  wire logic [7:0]         phase_count_select,
	output logic                    core_reg_en,
	output logic                    driver_reg_en,
	output logic                    clock_chain_out,
	output logic                    trip_bus_out,
	output logic                    trip_bus_oe_n,
	output mbs_pkg::mbs_gates_t     gates,
	output logic                    output_ok_out,
	output logic                    output_ok_oe_n,
	output logic [1:0]              ref_sel,
	output logic                    soft_start_run,
	output logic [3:0]              phase_count
);
	import mbs_pkg::*;

	localparam int unsigned SW = $bits(mbs_pins_t) + 8;

	logic [SW-1:0] sync_out;
	mbs_pins_t     ps;
	logic [7:0]    ratio_s;

	mbs_sync3 #(.W(SW)) u_sync (
		.mclk (mclk),
		.rst  (rst),
		.din  ({pins, phase_count_select}),
		.dout (sync_out)
	);
	assign {ps, ratio_s} = sync_out;

	mbs_state_t  st_q, st_d;
	logic [17:0] tmr_q, tmr_d;
	logic [3:0]  cfg_q, cfg_d;
	logic        restart_q, restart_d;
	logic [2:0]  ov_cnt_q, ov_cnt_d;
	logic [5:0]  pos_q, pos_d;
	logic        lock_prev_q;
	logic [6:0]  lock_age_q, lock_age_d;
	logic [1:0]  oc_cut_q, oc_cut_d;
	logic        oc_seen_q, oc_seen_d;
	logic [8:0]  oc_sum_q, oc_sum_d;
	logic [4:0]  clean_q, clean_d;
	logic [3:0]  fast_q, fast_d;
	logic [6:0]  ov_tmr_q, ov_tmr_d;
	logic        hs_seen_q, hs_seen_d;
	logic [15:0] ok_tmr_q, ok_tmr_d;
	logic        ls_allow_q, ls_allow_d;
	logic [5:0]  ramp_q, ramp_d;
	logic [9:0]  ramp_tmr_q, ramp_tmr_d;
	logic        run, lock_rise, oc_fault, ov_fault, ok_done;
	logic [1:0]  oc_evt, oc_add, cyc_start;
	mbs_gates_t  gates_d;
	logic        chain_d, bus_oe_n_d, ok_oe_n_d, ss_d;
	logic [1:0]  ref_d;
	logic [5:0]  dly;

	function automatic logic [5:0] phase_pos(input logic [5:0] p, input logic second);
		if (!second)
			return p;
		return (p >= HALF_CYC) ? 6'(p - HALF_CYC) : 6'(p + HALF_CYC);
	endfunction

	assign run       = (st_q == ST_RUN);
	assign lock_rise = ps.clock_lock_in & ~lock_prev_q;
	assign ok_done   = (ok_tmr_q == 16'(OKDLY_CYC));
	assign cyc_start = {pos_q == HALF_CYC, pos_q == 6'h0};
	// A standing hit still counts once per switching cycle of its phase
	assign oc_evt    = run ? (ps.oc_hit & (~oc_cut_q | cyc_start)) : 2'h0; // R12
	assign oc_add    = {1'b0, oc_evt[0]} + {1'b0, oc_evt[1]};

	// Protection counters and switching timebase
	always_comb begin
		pos_d = (pos_q == PERIOD_CYC - 6'h1) ? 6'h0 : 6'(pos_q + 6'h1);
		if (!ps.is_master && lock_rise)
			pos_d = 6'h0;
		lock_age_d = lock_rise ? 7'h0 : ((lock_age_q == LOCK_LOSS_CYC) ? lock_age_q : 7'(lock_age_q + 7'h1));
		// New cycle clears the cut, but a hit in that same cycle still sets it
		oc_cut_d = run ? ((oc_cut_q & ~cyc_start) | ps.oc_hit) : 2'h0; // R11
		oc_sum_d = 9'(oc_sum_q + {7'h0, oc_add}); // R12
		oc_seen_d = oc_seen_q | (|oc_evt);
		clean_d = clean_q;
		if (pos_q == 6'h0) begin
			oc_seen_d = |oc_evt;
			clean_d = oc_seen_q ? 5'h0 : 5'(clean_q + 5'h1); // R12
		end
		fast_d = fast_q;
		if (ps.is_master && ok_done && ps.fb_below_half)
			fast_d = 4'(fast_q + {2'h0, oc_add}); // R13
		if (clean_d == OC_CLEAN) begin
			clean_d = 5'h0;
			oc_sum_d = 9'h0;
			fast_d = 4'h0;
		end
		oc_fault = run && (oc_sum_d >= OC_LIMIT || fast_d >= OC_FAST); // R12 R13
		ov_tmr_d = (run && ps.is_master && ps.fb_above_ov) ? 7'(ov_tmr_q + 7'h1) : 7'h0;
		ov_fault = (ov_tmr_d == 7'(OVDLY_CYC)); // R16
		hs_seen_d = run && (hs_seen_q || |gates.high_side_gate);
		ok_tmr_d = (run && hs_seen_q && !ok_done) ? 16'(ok_tmr_q + 16'h1) : (run ? ok_tmr_q : 16'h0); // R8
		ls_allow_d = run && (ls_allow_q || ps.ss_above_fb); // R15
		ramp_d = ramp_q;
		ramp_tmr_d = ramp_tmr_q;
		if (!run || !restart_q) begin
			ramp_d = restart_q ? 6'h0 : PERIOD_CYC;
			ramp_tmr_d = 10'h0;
		end else if (ls_allow_q && ramp_q < PERIOD_CYC) begin
			// Low gate share widens one clock per step over the transition
			ramp_tmr_d = 10'(ramp_tmr_q + 10'h1); // R20
			if (ramp_tmr_q == 10'(RAMP_STEP_CYC - 1)) begin
				ramp_tmr_d = 10'h0;
				ramp_d = 6'(ramp_q + 6'h1);
			end
		end
		if (!run) begin
			oc_sum_d = 9'h0;
			clean_d = 5'h0;
			fast_d = 4'h0;
			oc_seen_d = 1'b0;
		end
	end

	// Sequencer
	always_comb begin
		st_d = st_q;
		tmr_d = 18'(tmr_q + 18'h1);
		cfg_d = cfg_q;
		restart_d = restart_q;
		ov_cnt_d = ov_cnt_q;
		if (!ps.enable_above) begin
			st_d = ST_OFF; // R1
			ov_cnt_d = 3'h0; // R18
		// Driver supply is still rising while waiting for it, not lost
		end else if (st_q != ST_OFF && st_q != ST_CORE_UP &&
			!(ps.core_ok && (ps.driver_ok || st_q == ST_DRV_UP))) begin
			st_d = ST_CORE_UP; // R2
			ov_cnt_d = 3'h0; // R18
		end else begin
			case (st_q)
				ST_OFF: begin
					st_d = ST_CORE_UP; // R1
				end
				ST_CORE_UP: begin
					if (ps.core_ok)
						st_d = ST_DRV_UP; // R1
				end
				ST_DRV_UP: begin
					if (ps.driver_ok)
						st_d = ST_SAMPLE; // R1
				end
				ST_SAMPLE: begin
					cfg_d = decode_phases(ratio_s); // R3 R4
					restart_d = 1'b0;
					tmr_d = 18'h0;
					st_d = ST_PLL;
				end
				ST_PLL: begin
					if (tmr_q == 18'(SETTLE_CYC - 1))
						st_d = ST_WAIT_BUS; // R5
				end
				ST_WAIT_BUS: begin
					if (ps.trip_bus_in)
						st_d = ST_PRECHARGE; // R5 R21
				end
				ST_PRECHARGE: begin
					tmr_d = 18'h0;
					if (!ps.trip_bus_in)
						st_d = ST_FAULT_WT; // R9
					else if (ps.err_amp_high)
						st_d = ST_BOOT; // R7
				end
				ST_BOOT: begin
					if (!ps.trip_bus_in)
						st_d = ST_FAULT_WT; // R9
					else if (tmr_q == 18'(BOOT_CYC - 1))
						st_d = ST_RUN; // R7
				end
				ST_RUN: begin
					tmr_d = 18'h0;
					if (oc_fault) begin
						st_d = ST_HICCUP; // R14
					end else if (ov_fault) begin
						st_d = ST_OV_PULL; // R16
						ov_cnt_d = 3'(ov_cnt_q + 3'h1); // R18
					end else if (!ps.trip_bus_in) begin
						st_d = ST_FAULT_WT; // R9 R21
					end
				end
				ST_HICCUP: begin
					if (tmr_q == 18'(HICCUP_CYC - 1))
						st_d = ST_FAULT_WT; // R14
				end
				ST_OV_PULL: begin
					tmr_d = 18'h0;
					if (!ps.fb_above_uv)
						st_d = ST_OV_WAIT; // R17
				end
				ST_OV_WAIT: begin
					if (tmr_q == 18'(OVWAIT_CYC - 1))
						st_d = (ov_cnt_q == OV_MAX) ? ST_LATCHED : ST_FAULT_WT; // R17 R18
				end
				ST_FAULT_WT: begin
					if (ps.trip_bus_in) begin
						st_d = ST_RUN; // R14 R15
						restart_d = 1'b1;
					end
				end
				ST_LATCHED: begin
					st_d = ST_LATCHED; // R18
				end
				default: begin
					st_d = ST_OFF;
				end
			endcase
		end
	end

	// Pins and gate drive
	always_comb begin
		gates_d = '0; // R10
		case (st_q)
			ST_PRECHARGE, ST_BOOT: begin
				gates_d.low_side_gate = 2'h3; // R7
			end
			ST_RUN: begin
				for (int i = 0; i < 2; i++) begin
					gates_d.high_side_gate[i] = ps.pwm_req[i] & ~oc_cut_q[i] & ~ps.oc_hit[i]; // R11
					gates_d.low_side_gate[i] = ~ps.pwm_req[i] & (~restart_q |
						(ls_allow_q & (phase_pos(pos_q, i[0]) < ramp_q))); // R15 R20
				end
			end
			ST_OV_PULL: begin
				gates_d.low_side_gate = 2'h3; // R16
			end
			default: begin
				gates_d = '0; // R9 R14
			end
		endcase
		// Released only where this device has nothing to report
		bus_oe_n_d = (st_q == ST_WAIT_BUS) || (st_q == ST_PRECHARGE) || (st_q == ST_BOOT) ||
			(st_q == ST_RUN) || (st_q == ST_FAULT_WT); // R5 R9 R14 R21
		dly = chain_delay(cfg_q);
		chain_d = (st_q >= ST_PLL) && (st_q != ST_LATCHED) && (pos_q >= dly) &&
			(pos_q < 6'(dly + HALF_CYC)); // R3
		ok_oe_n_d = run && ok_done && (ramp_q == PERIOD_CYC) && ps.follow_above_ref &&
			ps.trip_bus_in && (ps.is_master ? (ps.fb_above_uv && !ps.fb_above_ov) :
			(lock_age_q != LOCK_LOSS_CYC)); // R8 R19 R20
		ref_d = (run && restart_q && ps.ss_lowest) ? REF_SOFT :
			(ps.follow_above_ref ? REF_INTERNAL : REF_FOLLOW); // R6 R15
		ss_d = run && restart_q;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			st_q <= ST_OFF;
			tmr_q <= 18'h0;
			cfg_q <= 4'h0;
			restart_q <= 1'b0;
			ov_cnt_q <= 3'h0;
			pos_q <= 6'h0;
			lock_prev_q <= 1'b0;
			lock_age_q <= LOCK_LOSS_CYC;
			oc_cut_q <= 2'h0;
			oc_seen_q <= 1'b0;
			oc_sum_q <= 9'h0;
			clean_q <= 5'h0;
			fast_q <= 4'h0;
			ov_tmr_q <= 7'h0;
			hs_seen_q <= 1'b0;
			ok_tmr_q <= 16'h0;
			ls_allow_q <= 1'b0;
			ramp_q <= 6'h0;
			ramp_tmr_q <= 10'h0;
			core_reg_en <= 1'b0;
			driver_reg_en <= 1'b0;
			clock_chain_out <= 1'b0;
			trip_bus_out <= 1'b0;
			trip_bus_oe_n <= 1'b0;
			gates <= '0;
			output_ok_out <= 1'b0;
			output_ok_oe_n <= 1'b0;
			ref_sel <= REF_INTERNAL;
			soft_start_run <= 1'b0;
			phase_count <= 4'h0;
		end else begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			cfg_q <= cfg_d;
			restart_q <= restart_d;
			ov_cnt_q <= ov_cnt_d;
			pos_q <= pos_d;
			lock_prev_q <= ps.clock_lock_in;
			lock_age_q <= lock_age_d;
			oc_cut_q <= oc_cut_d;
			oc_seen_q <= oc_seen_d;
			oc_sum_q <= oc_sum_d;
			clean_q <= clean_d;
			fast_q <= fast_d;
			ov_tmr_q <= ov_tmr_d;
			hs_seen_q <= hs_seen_d;
			ok_tmr_q <= ok_tmr_d;
			ls_allow_q <= ls_allow_d;
			ramp_q <= ramp_d;
			ramp_tmr_q <= ramp_tmr_d;
			core_reg_en <= (st_q != ST_OFF); // R1
			driver_reg_en <= (st_q != ST_OFF) && (st_q != ST_CORE_UP); // R1
			clock_chain_out <= chain_d;
			trip_bus_out <= 1'b0; // R21
			trip_bus_oe_n <= bus_oe_n_d;
			gates <= gates_d;
			output_ok_out <= 1'b0; // R19
			output_ok_oe_n <= ok_oe_n_d;
			ref_sel <= ref_d;
			soft_start_run <= ss_d;
			phase_count <= cfg_q;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_settle_start;
		$rose(st_q == ST_PLL);
	endsequence
	sequence s_boot_start;
		$rose(st_q == ST_BOOT);
	endsequence

	AST_OFF_REGS: assert property (!ps.enable_above |-> ##2 !core_reg_en && !driver_reg_en) // R1
		else $error("regulators on while enable low");
	AST_STANDBY: assert property ((st_q == ST_RUN && !ps.core_ok) |-> ##2 gates == '0) // R2
		else $error("switching continued after supply loss");
	AST_SAMPLE_ONCE: assert property ((st_q != ST_SAMPLE) |=> $stable(cfg_q)) // R3
		else $error("phase configuration changed outside sampling");
	AST_SETTLE_HOLD: assert property (s_settle_start |=> !trip_bus_oe_n [*8]) // R5
		else $error("trip bus released during settling");
	AST_BOOT_PULSE: assert property (s_boot_start |=>
		(gates.low_side_gate == 2'h3 && gates.high_side_gate == 2'h0) [*8]) // R7
		else $error("boot pulse shape wrong");
	AST_FLOAT: assert property (!ps.enable_above |-> ##2 gates == '0) // R10
		else $error("gates driven while disabled");
	AST_OC_CUT: assert property ((run && ps.oc_hit[0]) |=> !gates.high_side_gate[0]) // R11
		else $error("high gate kept on past current limit");
	AST_OC_FAULT: assert property ((run && oc_sum_d >= OC_LIMIT) |=> st_q == ST_HICCUP) // R12
		else $error("over-current count did not fault");
	AST_HICCUP_HOLD: assert property ($rose(st_q == ST_HICCUP) |=> !trip_bus_oe_n && gates == '0) // R14
		else $error("hiccup without bus hold");
	AST_OV_GATES: assert property ((st_q == ST_OV_PULL) |=>
		gates.high_side_gate == 2'h0 && gates.low_side_gate == 2'h3) // R16
		else $error("over-voltage gate state wrong");
	AST_OK_DELAY: assert property ($rose(output_ok_oe_n) |-> $past(ok_done) && $past(run)) // R8
		else $error("output good released early");
endmodule // mbs_sequencer

// ---- dv/mbs_peer.sv ----
// Model of a neighbouring controller on the shared trip bus and sync chain
`timescale 1ns/1ps
module mbs_peer #(
	parameter int unsigned SETTLE = 40
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ready,
	input  wire logic fault_req,
	output logic      trip_oe_n,
	output logic      chain_clk
);
	import mbs_pkg::*;
	logic [15:0] cnt_q;
	logic [4:0]  ph_q;

	// Own settling hold, plus a commanded fault pull
	assign trip_oe_n = ready && cnt_q >= 16'(SETTLE) && !fault_req;

	always_ff @(posedge mclk) begin
		if (rst || !ready) begin
			cnt_q     <= 16'h0;
			ph_q      <= 5'h0;
			chain_clk <= 1'b0;
		end else begin
			if (cnt_q < 16'(SETTLE))
				cnt_q <= cnt_q + 16'h1;
			// Chain clock stands still while not ready
			ph_q <= (ph_q == 5'h18) ? 5'h0 : ph_q + 5'h1;
			if (ph_q == 5'h18)
				chain_clk <= !chain_clk;
		end
	end
endmodule // mbs_peer

// ---- dv/multiphase_buck_startup_fault_sequencer_tb_top.sv ----
// Self-checking bench of the buck startup and fault sequencer
`timescale 1ns/1ps
module multiphase_buck_startup_fault_sequencer_tb_top;
	import mbs_pkg::*;
	localparam int unsigned SC = 20;
	logic        mclk;
	logic        rst;
	mbs_pins_t   stim;
	mbs_pins_t   pins_w;
	logic [7:0]  phase_count_select;
	logic        core_reg_en, driver_reg_en, clock_chain_out, trip_bus_out;
	logic        trip_bus_oe_n, output_ok_out, output_ok_oe_n, soft_start_run;
	mbs_gates_t  gates;
	logic [1:0]  ref_sel;
	logic [3:0]  phase_count;
	logic        peer_oe_n, chain, fault_req, trip_bus;
	int          miscompares, n_checks, n;
	logic [7:0]  rt[7] = '{8'h00, 8'h37, 8'h5B, 8'h80, 8'hA4, 8'hC8, 8'hFF};
	logic [3:0]  pc[7] = '{4'h4, 4'h3, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC};

	// Pulled-up wired-AND of all released drivers
	assign trip_bus = trip_bus_oe_n & peer_oe_n;
	always_comb begin
		pins_w = stim;
		pins_w.trip_bus_in = trip_bus;
		pins_w.clock_lock_in = chain;
	end

	mbs_sequencer #(.SETTLE_CYC(SC), .HICCUP_CYC(SC), .OVWAIT_CYC(SC), .OKDLY_CYC(SC)) dut (
		.mclk(mclk), .rst(rst), .pins(pins_w), .phase_count_select(phase_count_select),
		.core_reg_en(core_reg_en), .driver_reg_en(driver_reg_en),
		.clock_chain_out(clock_chain_out), .trip_bus_out(trip_bus_out),
		.trip_bus_oe_n(trip_bus_oe_n), .gates(gates), .output_ok_out(output_ok_out),
		.output_ok_oe_n(output_ok_oe_n), .ref_sel(ref_sel), .soft_start_run(soft_start_run),
		.phase_count(phase_count));
	mbs_peer #(.SETTLE(40)) peer (.mclk(mclk), .rst(rst),
		.ready(stim.enable_above & stim.driver_ok), .fault_req(fault_req),
		.trip_oe_n(peer_oe_n), .chain_clk(chain));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = !mclk;
	end

	task automatic summarize;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			miscompares++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask

	function automatic logic sel(input int k);
		case (k)
			0: return trip_bus_oe_n;
			1: return core_reg_en;
			2: return driver_reg_en;
			3: return output_ok_oe_n;
			4: return |gates.high_side_gate;
			5: return &gates.low_side_gate;
			6: return |gates;
			default: return soft_start_run;
		endcase
	endfunction

	// Bounded wait; running out ends the run
	task automatic wait_for(input int k, input logic v, input int mx);
		n = 0;
		while (sel(k) !== v && n < mx) begin
			@(negedge mclk);
			n++;
		end
		chk(sel(k) === v, "bounded wait ran out");
		if (sel(k) !== v)
			summarize();
	endtask

	task automatic start_up(input logic [7:0] r, input logic [3:0] np);
		stim.enable_above = 1'b1;
		wait_for(1, 1'b1, 10);
		chk(driver_reg_en === 1'b0 && clock_chain_out === 1'b0, "driver or chain early");
		stim.core_ok = 1'b1;
		wait_for(2, 1'b1, 10);
		phase_count_select = r;
		stim.driver_ok = 1'b1;
		cyc(10);
		chk(phase_count === np, "phase decode");
		chk(gates === 4'h0 && trip_bus_oe_n === 1'b0, "bus held or gates early");
		wait_for(0, 1'b1, SC + 20);
		chk(n >= SC - 12, "settle too short");
		wait_for(5, 1'b1, 60);
		chk(trip_bus === 1'b1 && n >= 5, "switching before bus rise");
		stim.err_amp_high = 1'b1;
		wait_for(4, 1'b1, 30);
		chk(n >= BOOT_CYC && n <= BOOT_CYC + 10, "boot charge length");
	endtask

	task automatic shut;
		stim.enable_above = 1'b0;
		stim.core_ok = 1'b0;
		stim.driver_ok = 1'b0;
		stim.err_amp_high = 1'b0;
		wait_for(1, 1'b0, 10);
		chk(gates === 4'h0, "gates while off");
	endtask

	task automatic t_good;
		int   rises;
		logic prev;
		cyc(60);
		chk(output_ok_oe_n === 1'b0, "good without follow above ref");
		chk(ref_sel === REF_FOLLOW, "reference not follow");
		stim.follow_above_ref = 1'b1;
		wait_for(3, 1'b1, 30);
		chk(ref_sel === REF_INTERNAL, "reference not internal");
		chk(trip_bus_out === 1'b0 && output_ok_out === 1'b0, "open-drain data high");
		rises = 0;
		prev = clock_chain_out;
		repeat (100) begin
			@(negedge mclk);
			if (clock_chain_out && !prev)
				rises++;
			prev = clock_chain_out;
		end
		chk(rises == 2, "chain clock rate");
		stim.fb_above_uv = 1'b0;
		wait_for(3, 1'b0, 10);
		stim.fb_above_uv = 1'b1;
		wait_for(3, 1'b1, 30);
	endtask

	task automatic t_peer_fault;
		fault_req = 1'b1;
		wait_for(6, 1'b0, 10);
		cyc(30);
		chk(gates === 4'h0, "switching while bus low");
		fault_req = 1'b0;
		wait_for(4, 1'b1, 80);
	endtask

	task automatic t_hiccup_tail;
		chk(gates === 4'h0, "gates in hiccup");
		stim.oc_hit = 2'b00;
		stim.fb_below_half = 1'b0;
		wait_for(0, 1'b1, SC + 20);
		chk(n >= SC - 5, "hiccup too short");
		wait_for(7, 1'b1, 20);
		chk(ref_sel === REF_SOFT, "soft-start not selected");
		cyc(40);
		chk(output_ok_oe_n === 1'b0, "good before synchronous transition");
	endtask

	task automatic t_fast_oc;
		stim.fb_below_half = 1'b1;
		stim.ss_lowest = 1'b1;
		stim.oc_hit = 2'b01;
		wait_for(0, 1'b0, 8 * 50 + 20);
		chk(n >= 6 * 50 - 10, "fast fault too early");
		t_hiccup_tail();
	endtask

	task automatic t_sum_oc;
		wait_for(4, 1'b1, 3000);
		stim.oc_hit = 2'b11;
		cyc(10);
		chk(gates.high_side_gate === 2'b00, "cycle not cut");
		cyc(150 * 50);
		stim.oc_hit = 2'b00;
		cyc(20 * 50);
		stim.oc_hit = 2'b11;
		wait_for(0, 1'b0, 240 * 50);
		chk(n >= 215 * 50, "count not cleared or too low");
		t_hiccup_tail();
	endtask

	task automatic t_ov;
		for (int i = 1; i <= 7; i++) begin
			stim.fb_above_ov = 1'b1;
			wait_for(0, 1'b0, 140);
			chk(n >= 115, "over-voltage too fast");
			chk(gates === 4'h3, "over-voltage gates");
			stim.fb_above_ov = 1'b0;
			stim.fb_above_uv = 1'b0;
			wait_for(6, 1'b0, 10);
			stim.fb_above_uv = 1'b1;
			if (i < 7) begin
				wait_for(0, 1'b1, SC + 20);
				chk(n >= SC - 5, "over-voltage wait short");
				cyc(20);
			end else begin
				cyc(150);
				chk(trip_bus_oe_n === 1'b0 && gates === 4'h0, "restart after seventh");
			end
		end
	endtask

	task automatic t_supply;
		stim.core_ok = 1'b0;
		wait_for(6, 1'b0, 10);
		wait_for(0, 1'b0, 10);
		stim.core_ok = 1'b1;
		wait_for(0, 1'b1, SC + 40);
		wait_for(4, 1'b1, 80);
	endtask

	// Slaves ignore over-voltage and judge output-good by chain clock
	task automatic t_slave;
		stim.is_master = 1'b0;
		stim.fb_above_ov = 1'b1;
		cyc(200);
		chk(trip_bus_oe_n === 1'b1 && output_ok_oe_n === 1'b1, "slave tripped or not good");
		stim.fb_above_ov = 1'b0;
	endtask

	initial begin
		miscompares = 0;
		n_checks = 0;
		rst = 1'b1;
		fault_req = 1'b0;
		phase_count_select = 8'h00;
		stim = '0;
		stim.is_master = 1'b1;
		stim.fb_above_uv = 1'b1;
		stim.pwm_req = 2'b11;
		cyc(2);
		chk(trip_bus_oe_n === 1'b0 && gates === 4'h0 && core_reg_en === 1'b0, "reset");
		rst = 1'b0;
		for (int i = 0; i < 7; i++) begin
			start_up(rt[i], pc[i]);
			shut();
		end
		start_up(8'h00, 4'h4);
		t_good();
		t_peer_fault();
		t_fast_oc();
		t_sum_oc();
		t_ov();
		// Enable cycling must clear the latched over-voltage count
		shut();
		start_up(8'hFF, 4'hC);
		t_supply();
		t_slave();
		summarize();
	end
endmodule // multiphase_buck_startup_fault_sequencer_tb_top
